// [logic/lpu_uart.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// RL1: ninth tx bit defaults unless extended write
// RL2: multidrop address frame bypasses blocking, flags
// RL3: start frame unblock clears blocking, loads
// RL4: loopback feeds receiver from tx line
// RL5: error withholds rx dma when enabled
// RL6: invert flips both line polarities
// RL7: one or two tx stops, rx checks one
// RL8: parity none, even, odd selectable
// RL9: eight or nine data bits
// RL10: auto tristate floats idle tx line
// RL11: clear receive empties buffer and shifter
// RL12: clear transmit empties buffer and shifter
// RL13: blocking discards frames at completion
// RL14: rx disable drops partial frame
// RL15: enable commands and status flags
// RL16: tx buffer level set when empty
// RL17: tx complete after last frame
// RL18: rx valid follows buffer; idle resets high
// RL19: matches only while receiver enabled
// RL20: divider integer and fraction fields
// RL21: start match flag and load
// RL22: signal match flag
// RL23: dma wake gated by wake bits
// RL24: extended rx read pops with errors
// RL25: software avoids parity value one
module lpu_uart
	import lpu_pkg::*;
#(
	parameter int ABITS = 8
)(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ABITS-1:0]  paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              serialInPin,
	output logic                   serialOutPin,
	output logic                   serialOutOe,
	input  wire logic              deepSleepState,
	output logic                   rxDmaReq,
	output logic                   txDmaReq,
	output logic                   dmaWake
);
	import lpu_pkg::*;
	if (ABITS < 8)
	begin : g_abits
		$error("lpu_uart: address too narrow");
	end

	// ----------------------------------------
	// register bus decode
	// ----------------------------------------
	logic        wrAcc, rdAcc, hit;
	logic [7:0]  adr;
	assign adr = paddr[7:0];
	assign wrAcc = psel & penable & pwrite;
	assign rdAcc = psel & penable & ~pwrite;
	assign hit = adr == OFS_CTRL || adr == OFS_CMD || adr == OFS_STATUS
		|| adr == OFS_CLKDIV || adr == OFS_START || adr == OFS_SIGNAL
		|| adr == OFS_RXX || adr == OFS_RXB || adr == OFS_TXX
		|| adr == OFS_TXB || adr == OFS_FLAGS;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	logic [13:0] ctrl_r;
	logic [16:0] div_r;
	logic [8:0]  startVal_r, sigVal_r;
	logic [7:0]  cmd;
	assign cmd = (wrAcc && adr == OFS_CMD) ? pwdata[7:0] : 8'h00;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_r <= '0;
			div_r <= '0;
			startVal_r <= '0;
			sigVal_r <= '0;
		end
		else if (wrAcc)
		begin
			if (adr == OFS_CTRL)
				ctrl_r <= pwdata[13:0] & CTRL_MASK;
			if (adr == OFS_CLKDIV)
				div_r <= pwdata[16:0] & DIV_MASK; // RL20
			if (adr == OFS_START)
				startVal_r <= pwdata[8:0];
			if (adr == OFS_SIGNAL)
				sigVal_r <= pwdata[8:0];
		end
	end

	wire line_invert = ctrl_r[C_INV];
	wire nine = ctrl_r[C_DB];
	wire [1:0] par = ctrl_r[C_PARLO+1:C_PARLO];
	wire parOn = par[1]; // RL8
	wire parOdd = par[0];

	// ----------------------------------------
	// fractional baud tick: period 1+int+frac/32
	// ----------------------------------------
	logic [9:0] baudCnt_r;
	logic [4:0] fracAcc_r;
	logic       baudTick, fracCarry;
	wire  [5:0] fracSum = {1'b0, fracAcc_r} + {1'b0, div_r[7:3]};
	assign fracCarry = fracSum[5];
	assign baudTick = baudCnt_r == 10'h000;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			baudCnt_r <= '0;
			fracAcc_r <= '0;
		end
		else if (baudTick)
		begin
			fracAcc_r <= fracSum[4:0];
			baudCnt_r <= {1'b0, div_r[16:8]} + {9'h000, fracCarry};
		end
		else
			baudCnt_r <= baudCnt_r - 10'h001;
	end

	// ----------------------------------------
	// enables and blocking
	// ----------------------------------------
	logic rx_enable_cmd_r, tx_enable_cmd_r, block_r;
	logic frameDone, framing_error_bit, parity_error_bit;
	logic [8:0] rxWord;
	wire rxRun = rx_enable_cmd_r | cmd[K_RX_ENABLE_CMD];
	wire isMpa = ctrl_r[C_MPM] && rxWord[8] == ctrl_r[C_ADDRESS_BIT_VALUE]; // RL2
	wire isStart = rxWord == startVal_r; // RL21
	wire isSig = rxWord == sigVal_r; // RL22
	wire sfLoad = ctrl_r[C_SFUB] & isStart;
	wire loadRx = frameDone & (~block_r | isMpa | sfLoad); // RL13 RL2 RL3
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rx_enable_cmd_r <= 1'b0;
			tx_enable_cmd_r <= 1'b0;
			block_r <= 1'b0;
		end
		else
		begin
			if (cmd[K_RX_ENABLE_CMD]) rx_enable_cmd_r <= 1'b1; // RL15
			else if (cmd[K_RX_DISABLE_CMD]) rx_enable_cmd_r <= 1'b0;
			if (cmd[K_TX_ENABLE_CMD]) tx_enable_cmd_r <= 1'b1;
			else if (cmd[K_TX_DISABLE_CMD]) tx_enable_cmd_r <= 1'b0;
			if (frameDone && sfLoad) block_r <= 1'b0; // RL3
			else if (cmd[K_BLKON]) block_r <= 1'b1;
			else if (cmd[K_BLKOFF]) block_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	logic [8:0]  txBuf_r;
	logic        txFull_r, txBusy_r, txc_r, txLine_r, txPh_r;
	logic [11:0] txSh_r;
	logic [3:0]  txLeft_r;
	wire txbWr = wrAcc && adr == OFS_TXB;
	wire txxWr = wrAcc && adr == OFS_TXX;
	wire [8:0] txIn = txxWr ? pwdata[8:0]
		: {ctrl_r[C_B8DV], pwdata[7:0]}; // RL1
	wire txPar = ^(nine ? txBuf_r : {1'b0, txBuf_r[7:0]}) ^ parOdd;
	wire txStart = tx_enable_cmd_r & txFull_r & ~txBusy_r & baudTick;
	wire txStep = txBusy_r & baudTick & txPh_r;
	// frame bits lsb first after start; unused tail is stop level
	wire [11:0] txFrame = nine
		? {1'b1, parOn ? txPar : 1'b1, txBuf_r, 1'b0}
		: {2'b11, parOn ? txPar : 1'b1, txBuf_r[7:0], 1'b0};
	wire [3:0] txLen = 4'd10 + {3'b000, nine} + {3'b000, parOn}
		+ {3'b000, ctrl_r[C_STOP]}; // RL7 RL9
	always_ff @(posedge clk)
	begin
		if (!rst_n || cmd[K_CLRTX]) // RL12
		begin
			txFull_r <= 1'b0;
			txBusy_r <= 1'b0;
			txBuf_r <= '0;
			txSh_r <= '0;
			txLeft_r <= '0;
			txLine_r <= 1'b1;
			txPh_r <= 1'b0;
		end
		else
		begin
			if (txStart)
			begin
				txSh_r <= {1'b1, txFrame[11:1]};
				txLine_r <= txFrame[0];
				txLeft_r <= txLen - 4'd1;
				txBusy_r <= 1'b1;
				txFull_r <= 1'b0;
			end
			else if (txStep)
			begin
				txLine_r <= txLeft_r == 4'd0 ? 1'b1 : txSh_r[0];
				txSh_r <= {1'b1, txSh_r[11:1]};
				txBusy_r <= txLeft_r != 4'd0;
				txLeft_r <= txLeft_r - (txLeft_r != 4'd0 ? 4'd1 : 4'd0);
			end
			// a bit lasts two ticks, as the receiver samples it
			if (txBusy_r && baudTick)
				txPh_r <= ~txPh_r;
			// overflow keeps data already held
			if ((txbWr || txxWr) && !txFull_r)
			begin
				txBuf_r <= txIn;
				txFull_r <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			txc_r <= 1'b0;
		else if (txStart)
			txc_r <= 1'b0; // RL17
		else if (txStep && txLeft_r == 4'd0 && !txFull_r)
			txc_r <= 1'b1;
	end
	assign serialOutPin = txLine_r ^ line_invert; // RL6 RL10
	assign serialOutOe = ~ctrl_r[C_TRI] | txBusy_r; // RL10

	// ----------------------------------------
	// receiver, sampled on every second baud tick after start detect
	// ----------------------------------------
	logic rxS1_r, rxS2_r;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rxS1_r <= 1'b1;
			rxS2_r <= 1'b1;
		end
		else
		begin
			rxS1_r <= serialInPin;
			rxS2_r <= rxS1_r;
		end
	end
	// loopback taps the logical tx level before inversion cancels out
	wire rxBit = ctrl_r[C_LOOP] ? txLine_r : rxS2_r ^ line_invert; // RL4 RL6
	logic        rxAct_r, rxHalf_r;
	logic [10:0] rxSh_r;
	logic [3:0]  rxCnt_r;
	wire [3:0] rxLen = 4'd9 + {3'b000, nine} + {3'b000, parOn};
	wire [10:0] rxAl = rxSh_r >> (4'd11 - rxLen);
	assign rxWord = nine ? rxAl[8:0] : {1'b0, rxAl[7:0]};
	wire rxParBit = nine ? rxAl[9] : rxAl[8];
	wire stopBit = nine ? (parOn ? rxAl[10] : rxAl[9])
		: (parOn ? rxAl[9] : rxAl[8]);
	assign framing_error_bit = ~stopBit; // RL7
	assign parity_error_bit = parOn & ((^rxWord) ^ parOdd ^ rxParBit); // RL8
	assign frameDone = rxAct_r & baudTick & rxHalf_r & rxCnt_r == rxLen
		& rx_enable_cmd_r;
	always_ff @(posedge clk)
	begin
		if (!rst_n || cmd[K_CLRRX] || !rxRun || cmd[K_RX_DISABLE_CMD]) // RL11 RL14
		begin
			rxAct_r <= 1'b0;
			rxHalf_r <= 1'b0;
			rxSh_r <= '0;
			rxCnt_r <= '0;
		end
		else if (baudTick)
		begin
			if (!rxAct_r)
			begin
				rxAct_r <= ~rxBit;
				rxHalf_r <= 1'b0;
				rxCnt_r <= '0;
			end
			else
			begin
				rxHalf_r <= ~rxHalf_r;
				if (rxHalf_r)
				begin
					rxSh_r <= {rxBit, rxSh_r[10:1]};
					rxCnt_r <= rxCnt_r + 4'd1;
				end
				if (frameDone)
					rxAct_r <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// receive buffer and match flags
	// ----------------------------------------
	logic [10:0] rxBuf_r;
	logic        rxFull_r, start_match_flag_r, signal_match_flag_r, mpaF_r;
	wire rxPop = rdAcc && (adr == OFS_RXX || adr == OFS_RXB); // RL24
	always_ff @(posedge clk)
	begin
		if (!rst_n || cmd[K_CLRRX]) // RL11
		begin
			rxFull_r <= 1'b0;
			rxBuf_r <= '0;
		end
		else if (loadRx)
		begin
			rxBuf_r <= {framing_error_bit, parity_error_bit, rxWord}; // load wins over pop
			rxFull_r <= 1'b1;
		end
		else if (rxPop)
			rxFull_r <= 1'b0;
	end
	wire flagClr = wrAcc && adr == OFS_FLAGS;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			start_match_flag_r <= 1'b0;
			signal_match_flag_r <= 1'b0;
			mpaF_r <= 1'b0;
		end
		else
		begin
			// detection needs frameDone, which needs rx enabled; RL19
			start_match_flag_r <= (frameDone & isStart) | (start_match_flag_r
				& ~(flagClr & pwdata[0])); // RL21
			signal_match_flag_r <= (frameDone & isSig) | (signal_match_flag_r
				& ~(flagClr & pwdata[1])); // RL22
			mpaF_r <= (frameDone & isMpa) | (mpaF_r
				& ~(flagClr & pwdata[2])); // RL2
		end
	end

	// ----------------------------------------
	// dma requests and wake
	// ----------------------------------------
	wire rxErrHold = ctrl_r[C_ERRS] & (|rxBuf_r[10:9]);
	assign rxDmaReq = rxFull_r & ~rxErrHold; // RL5
	assign txDmaReq = ~txFull_r;
	assign dmaWake = deepSleepState & ((rxDmaReq & ctrl_r[C_RXWU])
		| (txDmaReq & ctrl_r[C_TXWU])); // RL23

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	wire [6:0] status = {~txBusy_r & ~txFull_r, rxFull_r, ~txFull_r,
		txc_r, block_r, tx_enable_cmd_r, rx_enable_cmd_r}; // RL15 RL16 RL18
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (rdAcc)
		begin
			unique case (adr)
				OFS_CTRL: prdata = {18'h00000, ctrl_r};
				OFS_STATUS: prdata = {25'h0000000, status};
				OFS_CLKDIV: prdata = {15'h0000, div_r};
				OFS_START: prdata = {23'h000000, startVal_r};
				OFS_SIGNAL: prdata = {23'h000000, sigVal_r};
				OFS_RXX: prdata = {16'h0000, rxBuf_r[10:9], 5'h00,
					rxBuf_r[8:0]}; // RL24
				OFS_RXB: prdata = {24'h000000, rxBuf_r[7:0]};
				OFS_FLAGS: prdata = {29'h00000000, mpaF_r, signal_match_flag_r,
					start_match_flag_r};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_TX_BUFFER_LEVEL_RESET: assert property (@(posedge clk)
		$rose(rst_n) |-> status[4]) else $error("tx level not 1"); // RL16
	AST_CLRRX: assert property (@(posedge clk) disable iff (!rst_n)
		cmd[K_CLRRX] |=> !rxFull_r) else $error("rx not cleared"); // RL11
	AST_CLRTX: assert property (@(posedge clk) disable iff (!rst_n)
		cmd[K_CLRTX] |=> !txFull_r && !txBusy_r)
		else $error("tx not cleared"); // RL12
	AST_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
		frameDone && block_r && !isMpa && !sfLoad && !rxFull_r
		|=> !rxFull_r) else $error("blocked frame loaded"); // RL13
	AST_RX_ENABLE_CMD: assert property (@(posedge clk) disable iff (!rst_n)
		cmd[K_RX_ENABLE_CMD] |=> status[0]) else $error("rx enable lost"); // RL15
	AST_ERRDMA: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl_r[C_ERRS] && rxFull_r && rxBuf_r[9] |-> !rxDmaReq)
		else $error("dma on error"); // RL5
	AST_INV: assert property (@(posedge clk) disable iff (!rst_n)
		!txBusy_r && !txStart ##1 !txBusy_r |-> serialOutPin == !line_invert)
		else $error("idle level wrong"); // RL6
	AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
		dmaWake |-> deepSleepState) else $error("wake outside sleep"); // RL23
endmodule
`default_nettype wire

// [logic/lpu_pkg.sv]
package lpu_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_CMD     = 8'h04;
	localparam logic [7:0] OFS_STATUS  = 8'h08;
	localparam logic [7:0] OFS_CLKDIV  = 8'h0c;
	localparam logic [7:0] OFS_START   = 8'h10;
	localparam logic [7:0] OFS_SIGNAL  = 8'h14;
	localparam logic [7:0] OFS_RXX     = 8'h18;
	localparam logic [7:0] OFS_RXB     = 8'h1c;
	localparam logic [7:0] OFS_TXX     = 8'h24;
	localparam logic [7:0] OFS_TXB     = 8'h28;
	localparam logic [7:0] OFS_FLAGS   = 8'h2c;
	// ----------------------------------------
	// control field positions
	// ----------------------------------------
	localparam int C_TRI   = 0;
	localparam int C_DB    = 1;
	localparam int C_PARLO = 2;
	localparam int C_STOP  = 4;
	localparam int C_INV   = 5;
	localparam int C_ERRS  = 6;
	localparam int C_LOOP  = 7;
	localparam int C_SFUB  = 8;
	localparam int C_MPM   = 9;
	localparam int C_ADDRESS_BIT_VALUE  = 10;
	localparam int C_B8DV  = 11;
	localparam int C_RXWU  = 12;
	localparam int C_TXWU  = 13;
	localparam logic [13:0] CTRL_MASK = 14'h3fff;
	// ----------------------------------------
	// command bits
	// ----------------------------------------
	localparam int K_RX_ENABLE_CMD = 0;
	localparam int K_RX_DISABLE_CMD = 1;
	localparam int K_TX_ENABLE_CMD = 2;
	localparam int K_TX_DISABLE_CMD = 3;
	localparam int K_BLKON = 4;
	localparam int K_BLKOFF = 5;
	localparam int K_CLRTX = 6;
	localparam int K_CLRRX = 7;
	// ----------------------------------------
	// divider and data layout
	// ----------------------------------------
	localparam int DIV_LSB = 3;
	localparam int DIV_MSB = 16;
	localparam logic [16:0] DIV_MASK = 17'h1fff8;
	localparam int FRAC_DEN = 32;
	localparam int RX_FRAMING_ERROR_BIT = 15;
	localparam int RX_PARITY_ERROR_BIT = 14;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [1:0] PAR_ODD  = 2'h3;
	localparam logic [6:0] STATUS_RST = 7'h50;
endpackage

// [verification/lpu_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module lpu_peer
#(
	parameter int BITCYC = 8
)(
	input  wire logic clk,
	output logic      line
);
	// released line rests high, as a pulled-up wire would
	initial line = 1'b1;
	task automatic sendBit(input logic b);
		@(posedge clk);
		line <= b;
		repeat (BITCYC - 1) @(posedge clk);
	endtask
	// lsb first; bad flips the parity bit on purpose
	task automatic sendFrame(input logic [8:0] d, input logic nine,
		input logic [1:0] par, input logic bad);
		int i;
		sendBit(1'b0);
		for (i = 0; i < (nine ? 9 : 8); i++)
			sendBit(d[i]);
		if (par[1])
			sendBit(^(nine ? d : {1'b0, d[7:0]}) ^ par[0] ^ bad);
		sendBit(1'b1);
	endtask
endmodule
`default_nettype wire

// [verification/lpu_uart_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lpu_uart_tb;
	import lpu_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] wd, ex; logic er;} lpu_row_t;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxLine;
	logic        txLine;
	logic        txOe;
	logic        sleep = 1'b0;
	logic        rxDma;
	logic        txDma;
	logic        wake;
	logic [31:0] rd;
	logic        se;
	int          err_count = 0;
	int          num_checks = 0;
	int          cycles = 0;
	lpu_row_t    rows [7];

	lpu_uart DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serialInPin(rxLine),
		.serialOutPin(txLine), .serialOutOe(txOe),
		.deepSleepState(sleep), .rxDmaReq(rxDma),
		.txDmaReq(txDma), .dmaWake(wake));
	// one bit is two ticks of 1+3 cycles with the divider at 0x300
	lpu_peer #(.BITCYC(8)) PEER (.clk(clk), .line(rxLine));

	always #5 clk = ~clk;

	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard, well above the few thousand cycles expected
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			err_count++;
			print_verdict();
		end
	end

	task check(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// polls until receive data is valid; a miss shows in the next read
	task waitRx;
		int i;
		for (i = 0; i < 80; i++)
		begin
			apb(1'b0, OFS_STATUS, 32'h0);
			if (rd[5] === 1'b1)
				break;
		end
	endtask

	task rxFrame(input logic [8:0] d, input logic nine,
		input logic [1:0] par, input logic bad);
		PEER.sendFrame(d, nine, par, bad);
		waitRx();
	endtask

	task status(input logic [31:0] m, ex);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("status", rd & m, ex);
	endtask

	initial
	begin
		rows = '{'{OFS_CTRL, 32'hffffffff, 32'h3fff, 1'b0},
			'{OFS_CTRL, 32'h0, 32'h0, 1'b0},
			'{OFS_CLKDIV, 32'hffffffff, 32'h1fff8, 1'b0},
			'{OFS_CLKDIV, 32'h300, 32'h300, 1'b0},
			'{OFS_START, 32'hfff, 32'h1ff, 1'b0},
			'{OFS_SIGNAL, 32'h2aa, 32'h0aa, 1'b0},
			'{8'h40, 32'h1, 32'h0, 1'b1}};
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		status(32'hffffffff, 32'h50);
		check("idle level", {31'h0, txLine}, 32'h1);
		$display("reset test done");
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].wd);
			apb(1'b0, rows[i].a, 32'h0);
			if (!rows[i].er)
				check("reg read", rd, rows[i].ex);
			check("slverr", {31'h0, se}, {31'h0, rows[i].er});
		end
		$display("register test done");
		// the all-ones divider row leaves a long count to run out
		repeat (600) @(posedge clk);
		apb(1'b1, OFS_CMD, 32'h1 << K_RX_ENABLE_CMD);
		rxFrame(9'h0a5, 1'b0, 2'h0, 1'b0);
		apb(1'b0, OFS_RXX, 32'h0);
		check("rx word", rd, 32'h0a5);
		status(32'h21, 32'h01);
		apb(1'b1, OFS_CTRL, 32'h4a);
		rxFrame(9'h1c3, 1'b1, PAR_EVEN, 1'b1);
		check("dma held", {31'h0, rxDma}, 32'h0);
		apb(1'b0, OFS_RXX, 32'h0);
		check("rx parity_error_bit", rd, 32'h41c3);
		apb(1'b1, OFS_CTRL, 32'h4e);
		rxFrame(9'h055, 1'b1, PAR_ODD, 1'b0);
		check("dma req", {31'h0, rxDma}, 32'h1);
		apb(1'b0, OFS_RXX, 32'h0);
		check("rx odd", rd, 32'h055);
		$display("format test done");
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_CMD, 32'h1 << K_BLKON);
		PEER.sendFrame(9'h011, 1'b0, 2'h0, 1'b0);
		repeat (40) @(posedge clk);
		status(32'h24, 32'h04);
		apb(1'b1, OFS_START, 32'h3c);
		apb(1'b1, OFS_CTRL, 32'h100);
		rxFrame(9'h03c, 1'b0, 2'h0, 1'b0);
		status(32'h4, 32'h0);
		apb(1'b0, OFS_RXX, 32'h0);
		check("start frame", rd, 32'h03c);
		apb(1'b0, OFS_FLAGS, 32'h0);
		check("start flag", rd & 32'h1, 32'h1);
		apb(1'b1, OFS_SIGNAL, 32'h77);
		rxFrame(9'h077, 1'b0, 2'h0, 1'b0);
		apb(1'b0, OFS_FLAGS, 32'h0);
		check("signal flag", rd & 32'h2, 32'h2);
		apb(1'b1, OFS_CMD, 32'h1 << K_CLRRX);
		status(32'h20, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h602);
		apb(1'b1, OFS_CMD, 32'h1 << K_BLKON);
		rxFrame(9'h1aa, 1'b1, 2'h0, 1'b0);
		apb(1'b0, OFS_RXX, 32'h0);
		check("address frame", rd, 32'h1aa);
		apb(1'b0, OFS_FLAGS, 32'h0);
		check("address flag", rd & 32'h4, 32'h4);
		$display("match test done");
		apb(1'b1, OFS_CMD, 32'h1 << K_BLKOFF);
		apb(1'b1, OFS_CTRL, 32'h1000);
		sleep <= 1'b1;
		rxFrame(9'h012, 1'b0, 2'h0, 1'b0);
		check("rx wake", {31'h0, wake}, 32'h1);
		apb(1'b0, OFS_RXB, 32'h0);
		@(posedge clk);
		check("wake gated", {31'h0, wake}, 32'h0);
		sleep <= 1'b0;
		fork
			PEER.sendFrame(9'h0f0, 1'b0, 2'h0, 1'b0);
			begin
				repeat (40) @(posedge clk);
				apb(1'b1, OFS_CMD, 32'h1 << K_RX_DISABLE_CMD);
			end
		join
		apb(1'b1, OFS_CMD, 32'h1 << K_RX_ENABLE_CMD);
		status(32'h21, 32'h01);
		$display("dma and abort test done");
		apb(1'b1, OFS_CTRL, 32'h80);
		apb(1'b1, OFS_CMD, 32'h1 << K_TX_ENABLE_CMD);
		apb(1'b1, OFS_TXB, 32'h5a);
		waitRx();
		apb(1'b0, OFS_RXX, 32'h0);
		check("loopback", rd, 32'h05a);
		repeat (40) @(posedge clk);
		status(32'h7b, 32'h5b);
		// nine bits, even parity, two stops, default ninth bit set
		apb(1'b1, OFS_CTRL, 32'h89a);
		apb(1'b1, OFS_TXX, 32'h0c3);
		waitRx();
		apb(1'b0, OFS_RXX, 32'h0);
		check("tx word", rd, 32'h0c3);
		apb(1'b1, OFS_TXB, 32'h3c);
		waitRx();
		apb(1'b0, OFS_RXX, 32'h0);
		check("ninth default", rd, 32'h13c);
		apb(1'b1, OFS_TXB, 32'h11);
		apb(1'b1, OFS_CMD, 32'h1 << K_CLRTX);
		status(32'h50, 32'h50);
		apb(1'b1, OFS_CMD, 32'h1 << K_TX_DISABLE_CMD);
		status(32'h2, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h20);
		@(posedge clk);
		check("inverted idle", {31'h0, txLine}, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h2001);
		sleep <= 1'b1;
		@(posedge clk);
		check("tristate", {31'h0, txOe}, 32'h0);
		check("tx dma", {31'h0, txDma}, 32'h1);
		check("tx wake", {31'h0, wake}, 32'h1);
		$display("transmit test done");
		print_verdict();
	end
endmodule
`default_nettype wire
